// [pkg/icc_ctrl_regs.vh]
// Register map, field positions, reset values and state codes of the
// two-wire controller's configuration block.
// Assumes a 32-bit classic Wishbone slave with byte addresses.
`ifndef ICC_CTRL_REGS_VH
`define ICC_CTRL_REGS_VH

// Word offsets (byte addresses).
`define ICC_OFS_CONTROL 8'h00
`define ICC_OFS_OWN_ADDR 8'h08
`define ICC_OFS_RAW_IRQ 8'h34
`define ICC_OFS_ENABLE 8'h6c
`define ICC_OFS_MST_REQ 8'hb0

// Control word fields.
`define ICC_CW_MASTER_MODE 0
`define ICC_CW_SPEED_LO 1
`define ICC_CW_SPEED_HI 2
`define ICC_CW_SLV_TEN_BIT 3
`define ICC_CW_MST_TEN_BIT 4
`define ICC_CW_RESTART_ALLOW 5
`define ICC_CW_SLAVE_OFF 6
`define ICC_CW_STOP_ADDR_ONLY 7
`define ICC_CW_TX_EMPTY_CTRL 8
`define ICC_CW_RX_FULL_HOLD 9
`define ICC_CW_MST_STOP_POLICY 10
`define ICC_CW_WIDTH 11

// Control word reset value and mask of the bits software may write.
`define ICC_CW_RESET 11'h065
`define ICC_CW_WR_MASK 11'h3ff

// Raw interrupt status fields.
`define ICC_RAW_RX_OVER 1
`define ICC_RAW_TX_EMPTY 4
`define ICC_RAW_TX_ABORT 6
`define ICC_RAW_STOP_SEEN 9
`define ICC_RAW_WIDTH 10

// Master request bits: operations that need a repeated start.
`define ICC_REQ_START_BYTE 0
`define ICC_REQ_HIGH_SPEED 1
`define ICC_REQ_DIR_CHANGE 2
`define ICC_REQ_TEN_BIT_READ 3
`define ICC_REQ_WIDTH 4

// Own slave address reset value.
`define ICC_OWN_ADDR_RESET 10'h055

// Slave receive states.
`define ICC_ST_IDLE 2'h0
`define ICC_ST_ADDR 2'h1
`define ICC_ST_ACK 2'h2
`define ICC_ST_REST 2'h3

`endif

// [core/icc_sync.v]
// Two flip-flop synchroniser for a group of asynchronous levels.
// Assumes the inputs come from pins outside the mclk domain.
`timescale 1ns/1ps

module icc_sync #(
	parameter WIDTH = 2
) (
	input wire mclk, // System clock.
	input wire sys_rst, // Synchronous reset, active high.
	input wire [WIDTH-1:0] asyncIn, // Levels from outside the domain.
	output reg [WIDTH-1:0] syncOut // Levels safe to use in mclk domain.
);

	reg [WIDTH-1:0] metaStage;

	// The first stage feeds only the second; idle bus lines are high.
	always @(posedge mclk)
	begin
		if (sys_rst)
		begin
			metaStage <= {WIDTH{1'b1}};
			syncOut <= {WIDTH{1'b1}};
		end
		else
		begin
			metaStage <= asyncIn;
			syncOut <= metaStage;
		end
	end

endmodule

// [core/icc_link_mon.v]
// Bus condition detector: clock edges, start and stop conditions.
// Assumes already synchronised clock and data lines on mclk.
`timescale 1ns/1ps

module icc_link_mon (
	input wire mclk, // System clock.
	input wire sys_rst, // Synchronous reset, active high.
	input wire sclIn, // Synchronised clock line.
	input wire sdaIn, // Synchronised data line.
	output reg sclRise, // One-cycle pulse on clock rising edge.
	output reg sclFall, // One-cycle pulse on clock falling edge.
	output reg startSeen, // One-cycle pulse on start or repeated start.
	output reg stopSeen // One-cycle pulse on stop.
);

	reg sclPrev;
	reg sdaPrev;

	// Data changing while the clock is high marks a start or a stop.
	always @(posedge mclk)
	begin
		if (sys_rst)
		begin
			sclPrev <= 1'b1;
			sdaPrev <= 1'b1;
			sclRise <= 1'b0;
			sclFall <= 1'b0;
			startSeen <= 1'b0;
			stopSeen <= 1'b0;
		end
		else
		begin
			sclPrev <= sclIn;
			sdaPrev <= sdaIn;
			sclRise <= sclIn & ~sclPrev;
			sclFall <= ~sclIn & sclPrev;
			startSeen <= sclIn & sclPrev & sdaPrev & ~sdaIn;
			stopSeen <= sclIn & sclPrev & ~sdaPrev & sdaIn;
		end
	end

endmodule

// [core/icc_ctrl_top.v]
// Configuration control word of a two-wire serial bus controller, with
// its enable, own address, raw status and master request registers, and
// the slave address and stop logic that the control word steers.
// Assumes a classic Wishbone master on mclk and bus pins from outside.
`timescale 1ns/1ps
`include "icc_ctrl_regs.vh"

module icc_ctrl_top (
	input wire mclk, // System clock, 125 MHz.
	input wire sys_rst, // Synchronous reset, active high.
	input wire wb_cyc_i, // Wishbone cycle.
	input wire wb_stb_i, // Wishbone strobe.
	input wire wb_we_i, // Wishbone write enable.
	input wire [7:0] wb_adr_i, // Wishbone byte address.
	input wire [3:0] wb_sel_i, // Wishbone byte selects.
	input wire [31:0] wb_dat_i, // Wishbone write data.
	output reg [31:0] wb_dat_o, // Wishbone read data.
	output reg wb_ack_o, // Wishbone acknowledge.
	input wire sclIn, // Clock line level from the pin.
	input wire sdaIn, // Data line level from the pin.
	output reg sclOut, // Clock line drive value, always low.
	output reg sclOe, // Clock line output enable, high pulls low.
	output reg sdaOut, // Data line drive value, always low.
	output reg sdaOe, // Data line output enable, high pulls low.
	input wire rxFifoFull, // Receive FIFO holds its full depth.
	input wire rxByteDone, // Pulse: a received byte wants the FIFO.
	input wire txFifoEmpty, // Transmit FIFO at or below threshold.
	input wire txShiftBusy, // Transmit shifter still sending a byte.
	output reg mstTenBit, // Master starts with ten-bit addressing.
	output reg mstSplitXfer, // Master uses stop and start for restarts.
	output reg mstReqGo, // Pulse: an accepted master request.
	output reg [3:0] mstReqOp, // Operations of the last written request that was not refused, even while disabled.
	output reg rxOverflow, // Pulse: a received byte was lost.
	output reg slaveActive // Slave role is answering on the bus.
);

	reg [`ICC_CW_WIDTH-1:0] controlWord;
	reg ctrlEnable;
	reg [9:0] ownSlaveAddr;
	reg [`ICC_RAW_WIDTH-1:0] rawIrqStatus;
	reg [1:0] slvState;
	reg [3:0] bitCnt;
	reg [7:0] shiftByte;
	reg ackDriven;
	reg addressedHit;
	wire [1:0] syncLines;
	wire sclSync;
	wire sdaSync;
	wire sclRise;
	wire sclFall;
	wire startSeen;
	wire stopSeen;
	wire busReq;
	wire wrStrobe;
	wire [31:0] wrMask;
	wire [31:0] wrData;
	wire [7:0] fullByte;
	wire ownHit;
	wire genCallHit;
	wire slaveOn;
	wire stopQualifies;
	wire rxOverNow;
	wire abortNow;
	wire txEmptyNow;
	reg [31:0] next_rdData;

	// Pins pass two flip-flops before any logic looks at them.
	icc_sync #(
		.WIDTH(2)
	) uSync (
		.mclk(mclk),
		.sys_rst(sys_rst),
		.asyncIn({sclIn, sdaIn}),
		.syncOut(syncLines)
	);

	assign sclSync = syncLines[1];
	assign sdaSync = syncLines[0];

	icc_link_mon uMon (
		.mclk(mclk),
		.sys_rst(sys_rst),
		.sclIn(sclSync),
		.sdaIn(sdaSync),
		.sclRise(sclRise),
		.sclFall(sclFall),
		.startSeen(startSeen),
		.stopSeen(stopSeen)
	);

	// A request is answered one cycle after it appears; ack never stays
	// high two cycles, so a held request is not taken twice.
	assign busReq = wb_cyc_i & wb_stb_i & ~wb_ack_o;
	assign wrStrobe = busReq & wb_we_i;
	assign wrMask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
	assign wrData = wb_dat_i & wrMask;

	// Slave role answers only when enabled and not switched off.
	assign slaveOn = ctrlEnable & ~controlWord[`ICC_CW_SLAVE_OFF];
	assign fullByte = {shiftByte[6:0], sdaSync};
	assign ownHit = (fullByte[7:1] == ownSlaveAddr[6:0]);
	assign genCallHit = (fullByte == 8'h00);

	// Master mode flags every stop; slave may restrict it to addressed ones.
	assign stopQualifies = controlWord[`ICC_CW_MASTER_MODE] ? 1'b1
		: (slaveActive & (~controlWord[`ICC_CW_STOP_ADDR_ONLY] | addressedHit));

	// Without bus hold, a byte that meets a full FIFO is lost.
	assign rxOverNow = rxByteDone & rxFifoFull & ~controlWord[`ICC_CW_RX_FULL_HOLD];

	// Any restart-needing operation is refused while restarts are off.
	assign abortNow = wrStrobe & (wb_adr_i == `ICC_OFS_MST_REQ) & wb_sel_i[0]
		& ~controlWord[`ICC_CW_RESTART_ALLOW] & (|wb_dat_i[`ICC_REQ_WIDTH-1:0]);

	// Controlled mode holds the flag off until the last byte has left.
	assign txEmptyNow = controlWord[`ICC_CW_TX_EMPTY_CTRL] ? (txFifoEmpty & ~txShiftBusy)
		: txFifoEmpty;

	// Register writes and the control word's write protection.
	always @(posedge mclk)
	begin
		if (sys_rst)
		begin
			controlWord <= `ICC_CW_RESET;
			ctrlEnable <= 1'b0;
			ownSlaveAddr <= `ICC_OWN_ADDR_RESET;
		end
		else if (wrStrobe)
		begin
			// Writes while enabled are dropped, and only the writable field
			// bits are taken; bit 10 and the reserved bits stay put.
			if (wb_adr_i == `ICC_OFS_CONTROL && !ctrlEnable)
			begin
				controlWord <= (controlWord & ~(`ICC_CW_WR_MASK & wrMask[10:0]))
					| (wrData[10:0] & `ICC_CW_WR_MASK);
			end
			if (wb_adr_i == `ICC_OFS_ENABLE && wb_sel_i[0])
			begin
				ctrlEnable <= wb_dat_i[0];
			end
			if (wb_adr_i == `ICC_OFS_OWN_ADDR && !ctrlEnable)
			begin
				ownSlaveAddr <= (ownSlaveAddr & ~wrMask[9:0]) | wrData[9:0];
			end
		end
	end

	// Raw status: sticky bits clear on a one written, and a new event
	// in the same cycle wins over the clear. Transmit empty is live.
	always @(posedge mclk)
	begin
		if (sys_rst)
		begin
			rawIrqStatus <= {`ICC_RAW_WIDTH{1'b0}};
		end
		else
		begin
			if (wrStrobe && wb_adr_i == `ICC_OFS_RAW_IRQ)
			begin
				rawIrqStatus <= rawIrqStatus & ~wrData[`ICC_RAW_WIDTH-1:0];
			end
			if (rxOverNow)
			begin
				rawIrqStatus[`ICC_RAW_RX_OVER] <= 1'b1;
			end
			if (abortNow)
			begin
				rawIrqStatus[`ICC_RAW_TX_ABORT] <= 1'b1;
			end
			if (stopSeen && stopQualifies)
			begin
				rawIrqStatus[`ICC_RAW_STOP_SEEN] <= 1'b1;
			end
			rawIrqStatus[`ICC_RAW_TX_EMPTY] <= txEmptyNow;
		end
	end

	// Read multiplexer; unmapped addresses read zero and still ack.
	always @*
	begin
		next_rdData = 32'h00000000;
		case (wb_adr_i)
			`ICC_OFS_CONTROL: next_rdData[`ICC_CW_WIDTH-1:0] = controlWord;
			`ICC_OFS_OWN_ADDR: next_rdData[9:0] = ownSlaveAddr;
			`ICC_OFS_RAW_IRQ: next_rdData[`ICC_RAW_WIDTH-1:0] = rawIrqStatus;
			`ICC_OFS_ENABLE: next_rdData[0] = ctrlEnable;
			default: next_rdData = 32'h00000000;
		endcase
	end

	// Bus answer and master-side outputs.
	always @(posedge mclk)
	begin
		if (sys_rst)
		begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h00000000;
			mstTenBit <= 1'b0;
			mstSplitXfer <= 1'b0;
			mstReqGo <= 1'b0;
			mstReqOp <= 4'h0;
			rxOverflow <= 1'b0;
		end
		else
		begin
			wb_ack_o <= busReq;
			wb_dat_o <= busReq ? next_rdData : 32'h00000000;
			mstTenBit <= controlWord[`ICC_CW_MST_TEN_BIT];
			mstSplitXfer <= ~controlWord[`ICC_CW_RESTART_ALLOW];
			// Refused requests never reach the master engine.
			mstReqGo <= wrStrobe & (wb_adr_i == `ICC_OFS_MST_REQ) & wb_sel_i[0]
				& ctrlEnable & ~abortNow;
			if (wrStrobe && wb_adr_i == `ICC_OFS_MST_REQ && wb_sel_i[0] && !abortNow)
			begin
				mstReqOp <= wb_dat_i[`ICC_REQ_WIDTH-1:0];
			end
			rxOverflow <= rxOverNow;
		end
	end

	// Slave address phase: shift eight bits, then acknowledge a match.
	always @(posedge mclk)
	begin
		if (sys_rst)
		begin
			slvState <= `ICC_ST_IDLE;
			bitCnt <= 4'h0;
			shiftByte <= 8'h00;
			ackDriven <= 1'b0;
			addressedHit <= 1'b0;
			sdaOe <= 1'b0;
			slaveActive <= 1'b0;
		end
		else
		begin
			slaveActive <= slaveOn;
			if (stopSeen || !slaveOn)
			begin
				slvState <= `ICC_ST_IDLE;
				addressedHit <= 1'b0;
				sdaOe <= 1'b0;
			end
			else if (startSeen)
			begin
				slvState <= `ICC_ST_ADDR;
				bitCnt <= 4'h0;
				shiftByte <= 8'h00;
				sdaOe <= 1'b0;
			end
			else
			begin
				case (slvState)
					`ICC_ST_ADDR:
					begin
						if (sclRise)
						begin
							shiftByte <= fullByte;
							bitCnt <= bitCnt + 4'h1;
							if (bitCnt == 4'h7)
							begin
								// A general call is acknowledged but never
								// counts as being addressed.
								if (ownHit || genCallHit)
								begin
									slvState <= `ICC_ST_ACK;
									ackDriven <= 1'b0;
									addressedHit <= addressedHit | ownHit;
								end
								else
								begin
									slvState <= `ICC_ST_REST;
								end
							end
						end
					end
					`ICC_ST_ACK:
					begin
						// Pull data low from one falling edge to the next.
						if (sclFall)
						begin
							ackDriven <= ~ackDriven;
							sdaOe <= ~ackDriven;
							if (ackDriven)
							begin
								slvState <= `ICC_ST_REST;
							end
						end
					end
					`ICC_ST_REST:
					begin
						sdaOe <= 1'b0;
					end
					default:
					begin
						sdaOe <= 1'b0;
					end
				endcase
			end
		end
	end

	// Bus hold stretches the clock low while the receive FIFO is full.
	// The hold only starts once the clock is already low, so it never
	// cuts a high phase short.
	always @(posedge mclk)
	begin
		if (sys_rst)
		begin
			sclOe <= 1'b0;
			sclOut <= 1'b0;
			sdaOut <= 1'b0;
		end
		else
		begin
			sclOe <= controlWord[`ICC_CW_RX_FULL_HOLD] & rxFifoFull & ctrlEnable
				& (sclOe | ~sclSync);
		end
	end

endmodule

// [tb/icc_ctrl_monitor.sv]
// Assertion checker for the control block's bus handshake and pins.
// Assumes it is bound to icc_ctrl_top and sees only its ports.
`timescale 1ns/1ps
module icc_ctrl_monitor (
	input wire mclk, // Clock.
	input wire sys_rst, // Reset.
	input wire wb_cyc_i, // Cycle.
	input wire wb_stb_i, // Strobe.
	input wire wb_we_i, // Write.
	input wire [7:0] wb_adr_i, // Address.
	input wire [31:0] wb_dat_o, // Read data.
	input wire wb_ack_o, // Acknowledge.
	input wire sdaOe, // Data pull.
	input wire rxFifoFull, // Queue full.
	input wire rxByteDone, // Byte in.
	input wire mstTenBit, // Ten-bit.
	input wire mstSplitXfer, // No restart.
	input wire mstReqGo, // Request taken.
	input wire [3:0] mstReqOp, // Request ops.
	input wire rxOverflow, // Byte lost.
	input wire slaveActive // Slave on.
);
	default clocking cb @(posedge mclk); endclocking
	default disable iff (sys_rst);
	// A request counts only while the previous ack is gone.
	sequence s_take;
		wb_cyc_i && wb_stb_i && !wb_ack_o;
	endsequence
	sequence s_wr;
		wb_stb_i && wb_we_i;
	endsequence
	a_ack_next: assert property (s_take |=> wb_ack_o)
		else $error("ack missing");
	a_ack_single: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack held");
	a_dat_idle: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
		else $error("read data not zero");
	a_go_restart: assert property (mstReqGo && mstReqOp != 4'h0 |-> !mstSplitXfer)
		else $error("restart request accepted");
	a_go_pulse: assert property (mstReqGo |=> !mstReqGo) else $error("request pulse long");
	a_ovf_cause: assert property (rxOverflow |-> $past(rxByteDone && rxFifoFull))
		else $error("overflow without cause");
	a_ovf_none: assert property (rxByteDone && !rxFifoFull |=> !rxOverflow)
		else $error("overflow with room");
	a_slave_quiet: assert property (!slaveActive [*8] |-> !sdaOe)
		else $error("disabled slave acks");
	// The mode outputs may move only right after a register write.
	a_cfg_by_write: assert property (!$stable({mstTenBit, mstSplitXfer}) |->
		$past(wb_stb_i && wb_we_i) || $past(wb_stb_i && wb_we_i, 2))
		else $error("mode changed without write");
	c_write: cover property (s_wr);
endmodule

bind icc_ctrl_top icc_ctrl_monitor u_mon (.mclk(mclk), .sys_rst(sys_rst), .wb_cyc_i(wb_cyc_i),
	.wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o),
	.wb_ack_o(wb_ack_o), .sdaOe(sdaOe), .rxFifoFull(rxFifoFull), .rxByteDone(rxByteDone),
	.mstTenBit(mstTenBit), .mstSplitXfer(mstSplitXfer), .mstReqGo(mstReqGo),
	.mstReqOp(mstReqOp), .rxOverflow(rxOverflow), .slaveActive(slaveActive));

// [tb/icc_bus_model.sv]
// Behavioural master on the two-wire bus: start, one byte, ack, stop.
// Assumes open-drain lines with pull-ups resolved by the bench.
`timescale 1ns/1ps
module icc_bus_model (
	input wire sdaLine, // Resolved data line.
	output reg sclLow, // Pulls clock low.
	output reg sdaLow // Pulls data low.
);
	// Lines released at rest, so the clock stands high between frames.
	initial
	begin
		sclLow = 1'b0;
		sdaLow = 1'b0;
	end
	// One frame at a 160 ns bit period; data moves while clock low except at start and stop.
	// Every line change lands 2 ns after an mclk edge. Changing a line on the
	// edge itself would race the synchroniser's sampling.
	task frame(input [7:0] b, output a);
		integer i;
	begin
		#2;
		sdaLow = 1'b1;
		#40;
		sclLow = 1'b1;
		for (i = 7; i >= 0; i = i - 1)
		begin
			sdaLow = ~b[i];
			#40;
			sclLow = 1'b0;
			#80;
			sclLow = 1'b1;
			#40;
		end
		sdaLow = 1'b0;
		#40;
		sclLow = 1'b0;
		#40;
		a = ~sdaLine;
		#40;
		sclLow = 1'b1;
		#40;
		sdaLow = 1'b1;
		#40;
		sclLow = 1'b0;
		#40;
		sdaLow = 1'b0;
		#80;
	end
	endtask
	// Holds the clock line low or lets it go, just off an mclk edge.
	task pull_clock(input l);
	begin
		#2;
		sclLow = l;
	end
	endtask
endmodule

// [tb/icc_ctrl_top_tb.sv]
// Self-checking bench for the control word block.
// Assumes the checker is bound in and the bus model drives the pins.
`timescale 1ns/1ps
module icc_ctrl_top_tb;
	reg mclk;
	reg sys_rst = 1'b1;
	reg cyc = 1'b0;
	reg stb = 1'b0;
	reg we = 1'b0;
	reg [7:0] adr = 8'h00;
	reg [31:0] wdat = 32'h0;
	reg [3:0] sel = 4'hf;
	integer goCount = 0;
	reg rxFifoFull = 1'b0;
	reg rxByteDone = 1'b0;
	reg txFifoEmpty = 1'b0;
	reg txShiftBusy = 1'b0;
	integer fail_count = 0;
	integer comparisons = 0;
	reg [31:0] q;
	reg a;
	wire [31:0] rdat;
	wire ack, sclOut, sclOe, sdaOut, sdaOe, mstTenBit, mstSplitXfer, mstReqGo;
	wire rxOverflow, slaveActive, mScl, mSda;
	wire [3:0] mstReqOp;
	// Open-drain lines with pull-ups: low if anyone pulls.
	wire sclLine = ~(mScl | sclOe);
	wire sdaLine = ~(mSda | sdaOe);

	icc_ctrl_top DUT (.mclk(mclk), .sys_rst(sys_rst), .wb_cyc_i(cyc), .wb_stb_i(stb),
		.wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat),
		.wb_ack_o(ack), .sclIn(sclLine), .sdaIn(sdaLine), .sclOut(sclOut), .sclOe(sclOe),
		.sdaOut(sdaOut), .sdaOe(sdaOe), .rxFifoFull(rxFifoFull), .rxByteDone(rxByteDone),
		.txFifoEmpty(txFifoEmpty), .txShiftBusy(txShiftBusy), .mstTenBit(mstTenBit),
		.mstSplitXfer(mstSplitXfer), .mstReqGo(mstReqGo), .mstReqOp(mstReqOp),
		.rxOverflow(rxOverflow), .slaveActive(slaveActive));
	icc_bus_model BUS (.sdaLine(sdaLine), .sclLow(mScl), .sdaLow(mSda));

	initial
	begin
		mclk = 1'b0;
		forever #4 mclk = ~mclk;
	end

	// Counts accepted master requests, because the pulse lasts only one cycle.
	always @(posedge mclk)
	begin
		if (mstReqGo === 1'b1)
			goCount <= goCount + 1;
	end

	task chk(input [31:0] got, input [31:0] exp);
	begin
		comparisons = comparisons + 1;
		if (got !== exp)
		begin
			fail_count = fail_count + 1;
			$display("unexpected at %0t: got %h want %h", $time, got, exp);
		end
	end
	endtask

	task end_of_test;
	begin
		$display("Compared %0d, mismatched %0d", comparisons, fail_count);
		if (fail_count == 0 && comparisons > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	end
	endtask

	// One classic cycle; read data is taken at the edge that sees ack.
	task wb(input w, input [7:0] ad, input [31:0] d);
		integer n;
	begin
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= ad;
		wdat <= d;
		n = 0;
		@(posedge mclk);
		while (ack !== 1'b1 && n < 20)
		begin
			@(posedge mclk);
			n = n + 1;
		end
		q = rdat;
		cyc <= 1'b0;
		stb <= 1'b0;
		@(posedge mclk);
		if (n >= 20)
		begin
			fail_count = fail_count + 1;
			end_of_test;
		end
	end
	endtask

	// The control word only takes writes with the controller disabled.
	task cfg(input [31:0] v);
	begin
		wb(1, 8'h6c, 0);
		wb(1, 8'h00, v);
		wb(1, 8'h6c, 1);
	end
	endtask

	task t_reset;
	begin
		wb(0, 8'h00, 0);
		chk(q, 32'h65);
		chk(slaveActive, 0);
		chk(mstSplitXfer, 0);
		chk({sclOut, sdaOut}, 0);
	end
	endtask

	task t_protect;
	begin
		wb(1, 8'h00, 32'hffffffff);
		wb(0, 8'h00, 0);
		chk(q, 32'h3ff);
		chk(mstTenBit, 1);
		sel <= 4'he;
		wb(1, 8'h00, 0);
		sel <= 4'hf;
		wb(0, 8'h00, 0);
		chk(q, 32'h0ff);
		wb(1, 8'h6c, 1);
		wb(1, 8'h00, 0);
		wb(0, 8'h00, 0);
		chk(q, 32'h0ff);
		wb(0, 8'h40, 0);
		chk(q, 0);
	end
	endtask

	task t_restart;
		integer i;
	begin
		cfg(32'h04);
		chk(mstSplitXfer, 1);
		chk(mstTenBit, 0);
		for (i = 0; i < 4; i = i + 1)
		begin
			wb(1, 8'hb0, 32'h1 << i);
			wb(0, 8'h34, 0);
			chk(q[6], 1);
			wb(1, 8'h34, 32'h40);
		end
		chk(goCount, 0);
		chk(mstReqOp, 0);
		cfg(32'h24);
		wb(1, 8'hb0, 32'h1);
		wb(0, 8'h34, 0);
		chk(q[6], 0);
		chk(goCount, 1);
		chk(mstReqOp, 1);
	end
	endtask

	// One frame, then the ack and the stop flag are judged.
	task frame(input [7:0] b, input ea, input es);
	begin
		wb(1, 8'h34, 32'h242);
		BUS.frame(b, a);
		@(posedge mclk);
		chk(a, ea);
		wb(0, 8'h34, 0);
		chk(q[9], es);
	end
	endtask

	task t_slave;
	begin
		cfg(32'ha4);
		frame(8'haa, 1, 1);
		frame(8'h00, 1, 0);
		cfg(32'h24);
		frame(8'h40, 0, 1);
		cfg(32'h64);
		frame(8'haa, 0, 0);
		cfg(32'h65);
		frame(8'haa, 0, 1);
	end
	endtask

	task rx_byte(input e);
	begin
		rxFifoFull <= 1'b1;
		rxByteDone <= 1'b1;
		@(posedge mclk);
		rxByteDone <= 1'b0;
		@(posedge mclk);
		chk(rxOverflow, e);
		chk(sclOe, 0);
		rxFifoFull <= 1'b0;
		@(posedge mclk);
	end
	endtask

	task t_rx;
	begin
		cfg(32'h64);
		rx_byte(1);
		wb(0, 8'h34, 0);
		chk(q[1], 1);
		cfg(32'h264);
		rx_byte(0);
		// A full queue during a low clock phase must keep the clock held low.
		BUS.pull_clock(1);
		repeat (4) @(posedge mclk);
		rxFifoFull <= 1'b1;
		repeat (2) @(posedge mclk);
		chk(sclOe, 1);
		BUS.pull_clock(0);
		repeat (4) @(posedge mclk);
		chk(sclLine, 0);
		rxFifoFull <= 1'b0;
		repeat (2) @(posedge mclk);
		chk(sclLine, 1);
	end
	endtask

	// The live flag follows its inputs one edge later.
	task t_tx;
	begin
		cfg(32'h164);
		txFifoEmpty <= 1'b1;
		txShiftBusy <= 1'b1;
		repeat (2) @(posedge mclk);
		wb(0, 8'h34, 0);
		chk(q[4], 0);
		txShiftBusy <= 1'b0;
		repeat (2) @(posedge mclk);
		wb(0, 8'h34, 0);
		chk(q[4], 1);
		cfg(32'h64);
		txShiftBusy <= 1'b1;
		repeat (2) @(posedge mclk);
		wb(0, 8'h34, 0);
		chk(q[4], 1);
	end
	endtask

	initial
	begin
		repeat (10) @(posedge mclk);
		sys_rst <= 1'b0;
		@(posedge mclk);
		t_reset;
		t_protect;
		t_restart;
		t_slave;
		t_rx;
		t_tx;
		end_of_test;
	end

	// Guard against a hang anywhere in the run.
	initial
	begin
		#500000;
		fail_count = fail_count + 1;
		end_of_test;
	end
endmodule
